// ### rtl/dao_addr_gen.sv
// Purpose : Works out operand addresses and result destinations.
// Assumes : Execution unit decodes the instruction class for us.
// Notes   : One request per cycle; results appear one cycle later.
//
// Summary of operation
// - Mode fixed per class, up to three options
// - Inherent ops carry no decoded address
// - Literal ops take constant from opcode
// - Call and jump carry 20-bit target
// - Direct address is opcode low byte
// - Quick bit one: bank select forms address
// - Quick bit zero: fixed quick-access bank, or pointer 2 indexed if extended set on and offset up to 5F
// - Full 12-bit address ignores bank select
// - Target bit one: result to register
// - Target bit zero: result to accumulator
// - No target bit: destination fixed by opcode
// - Indirect address comes from pointer register
// - Pointers are mapped, software-accessible registers
// - Indirect access may step or offset pointer
`timescale 1ns/100ps
module dao_addr_gen
    import dao_pkg::*;
(
    input  wire logic      core_clk_i,
    input  wire logic      rst_i,
    input  wire logic      req_valid_i,
    input  wire dao_req_s  req_i,
    input  wire dao_byte_t acc_i,
    input  wire logic      access_done_i,
    input  wire dao_addr_t reg_addr_i,
    input  wire dao_byte_t reg_wdata_i,
    input  wire logic      reg_wr_i,
    input  wire logic      reg_rd_i,
    output dao_byte_t      reg_rdata_o,
    output logic           res_valid_o,
    output dao_res_s       res_o
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [3:0]                 bsr_reg;
    logic                       ext_en_reg;
    logic                       pend_reg;
    logic [1:0]                 pend_idx_reg;
    logic [1:0]                 pend_kind_reg;
    dao_byte_t                  pend_off_reg;
    dao_byte_t                  rdata_reg;
    logic                       res_valid_reg;
    dao_res_s                   res_reg;
    dao_res_s                   res_next;
    logic [NUM_PTR-1:0][ADDR_W-1:0] ptr;

    // --------------------------------------------------------------
    // Opcode fields
    // --------------------------------------------------------------
    wire dao_byte_t op_addr8  = req_i.word0[OP_ADDR_MSB:OP_ADDR_LSB];
    wire            a_bit     = req_i.word0[OP_A_BIT];
    wire            d_bit     = req_i.word0[OP_D_BIT];
    wire            is_inh    = (req_i.cls == CLS_INHERENT);
    wire            is_lit    = (req_i.cls == CLS_LITERAL);
    wire            is_br     = (req_i.cls == CLS_BRANCH);
    wire            is_dird   = (req_i.cls == CLS_DIRECT_D);
    wire            is_dirb   = (req_i.cls == CLS_DIRECT_B);
    wire            is_fsrc   = (req_i.cls == CLS_FULL_SRC);
    wire            is_fdst   = (req_i.cls == CLS_FULL_DST);
    wire            is_full   = is_fsrc || is_fdst;
    wire            is_dir    = is_dird || is_dirb;
    wire            has_addr  = is_dir || is_full;

    // --------------------------------------------------------------
    // Address formation
    // --------------------------------------------------------------
    // low byte as direct address
    wire dao_addr_t access_addr = op_addr8[7]
                                ? {ACC_HIGH_BANK, op_addr8}
                                : {ACC_LOW_BANK, op_addr8};
    wire dao_addr_t banked_addr = {bsr_reg, op_addr8};
    wire dao_addr_t full_addr   = is_fsrc ? req_i.word0[OP_FULL_MSB:0]
                                          : req_i.word1[OP_FULL_MSB:0];
    // extended set adds an indexed option
    wire            idx_win     = ext_en_reg && is_dir && !a_bit
                                && (op_addr8 <= IDX_LIMIT);
    wire dao_addr_t idx_addr    = ptr[2] + {4'h0, op_addr8};

    // quick bank when the bit is clear
    wire dao_addr_t dir_addr    = a_bit ? banked_addr : access_addr;
    wire dao_addr_t eff_addr    = is_full ? full_addr
                                : idx_win ? idx_addr : dir_addr;

    // indirect locations redirect to a pointer
    wire            ind_hit     = has_addr && !idx_win
                                && (eff_addr[11:4] == IND_PAGE)
                                && (eff_addr[3:2] != IND_NONE_SLOT);
    wire [1:0]      ind_idx     = eff_addr[3:2];
    wire [1:0]      ind_kind    = eff_addr[1:0];
    wire dao_addr_t ind_addr    = ptr[ind_idx];

    // --------------------------------------------------------------
    // Result destination
    // --------------------------------------------------------------
    // target bit steers result
    wire            dest_reg    = is_dird ? d_bit
                                : (is_dirb || is_full || is_inh)
                                ? !req_i.fixed_acc : 1'b0;

    // --------------------------------------------------------------
    // Result assembly
    // --------------------------------------------------------------
    always_comb begin
        res_next           = '0;
        res_next.dest_reg  = dest_reg;
        res_next.has_addr  = has_addr;
        res_next.mode      = MODE_INHERENT;
        if (is_inh) begin
            res_next.mode = MODE_INHERENT;
        end
        if (is_lit) begin
            res_next.mode    = MODE_LITERAL;
            res_next.literal = op_addr8;
        end
        if (is_br) begin
            res_next.mode   = MODE_LITERAL;
            res_next.target = {req_i.word1[11:0], op_addr8};
        end
        if (has_addr) begin
            res_next.mode      = ind_hit ? MODE_INDIRECT
                               : idx_win ? MODE_INDEXED : MODE_DIRECT;
            res_next.data_addr = ind_hit ? ind_addr : eff_addr;
        end
    end

    // --------------------------------------------------------------
    // Pending pointer update
    // --------------------------------------------------------------
    wire new_pend = req_valid_i && ind_hit && (ind_kind != IND_PLAIN);
    // step only once the access is done
    wire upd_now  = pend_reg && access_done_i;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
        end else if (new_pend) begin
            pend_reg <= 1'b1;
        end else if (upd_now) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pend_idx_reg  <= 2'h0;
            pend_kind_reg <= IND_PLAIN;
            pend_off_reg  <= RST_BYTE;
        end else if (new_pend) begin
            pend_idx_reg  <= ind_idx;
            pend_kind_reg <= ind_kind;
            pend_off_reg  <= acc_i;
        end
    end

    // --------------------------------------------------------------
    // Register port decode
    // --------------------------------------------------------------
    wire [2*NUM_PTR-1:0] ptr_wr;
    wire [2*NUM_PTR-1:0] ptr_sel;
    genvar s;
    generate
        for (s = 0; s < 2*NUM_PTR; s++) begin : g_sel
            assign ptr_sel[s] = (reg_addr_i == SFR_PTR_BASE + ADDR_W'(s));
            assign ptr_wr[s]  = reg_wr_i && ptr_sel[s];
        end
    endgenerate

    wire sel_bsr  = (reg_addr_i == SFR_BSR);
    wire sel_ctrl = (reg_addr_i == SFR_CTRL);
    wire sel_stat = (reg_addr_i == SFR_STATUS);
    wire [3:0] ptr_byte_idx = reg_addr_i[3:0];
    wire dao_addr_t ptr_rd_word = ptr[ptr_byte_idx[2:1]];
    wire dao_byte_t ptr_rd_byte = ptr_byte_idx[0]
                                ? {4'h0, ptr_rd_word[11:8]}
                                : ptr_rd_word[7:0];
    // Unmapped addresses read as zero
    wire dao_byte_t rdata_next = (|ptr_sel) ? ptr_rd_byte
                               : sel_bsr  ? {4'h0, bsr_reg}
                               : sel_ctrl ? {7'h00, ext_en_reg}
                               : sel_stat ? {2'h0, pend_reg, res_reg.mode}
                               : RST_BYTE;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bsr_reg    <= 4'h0;
            ext_en_reg <= 1'b0;
        end else begin
            if (reg_wr_i && sel_bsr) begin
                bsr_reg <= reg_wdata_i[3:0];
            end
            if (reg_wr_i && sel_ctrl) begin
                ext_en_reg <= reg_wdata_i[CTRL_EXT_BIT];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_reg <= RST_BYTE;
        end else begin
            rdata_reg <= reg_rd_i ? rdata_next : RST_BYTE;
        end
    end

    // --------------------------------------------------------------
    // Result registers
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            res_valid_reg <= 1'b0;
            res_reg       <= '{mode: MODE_INHERENT, default: '0};
        end else begin
            res_valid_reg <= req_valid_i;
            if (req_valid_i) begin
                res_reg <= res_next;
            end
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign res_valid_o = res_valid_reg;
    assign res_o       = res_reg;

    // --------------------------------------------------------------
    // Pointer storage
    // --------------------------------------------------------------
    // pointers written through the port
    dao_ptr_file u_ptr (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .sw_wr_i    (ptr_wr),
        .sw_data_i  (reg_wdata_i),
        .upd_i      (upd_now),
        .upd_idx_i  (pend_idx_reg),
        .upd_kind_i (pend_kind_reg),
        .upd_off_i  (pend_off_reg),
        .ptr_o      (ptr)
    );

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    wire dao_addr_t pend_ptr = ptr[pend_idx_reg];
    wire            no_sw_wr = (ptr_wr == '0);

    sequence s_step_start;
        upd_now && no_sw_wr && (pend_kind_reg == IND_POSTINC);
    endsequence

    sequence s_hold_start;
        pend_reg && !access_done_i && no_sw_wr;
    endsequence

    sequence s_dec_start;
        upd_now && no_sw_wr && (pend_kind_reg == IND_POSTDEC);
    endsequence

    result_timing_a: assert property (
        req_valid_i |=> res_valid_o ##1 (res_valid_o == $past(req_valid_i))
    ) else $error("result valid not one cycle after request");

    inherent_mode_a: assert property (
        req_valid_i && is_inh |=> !res_o.has_addr
            && res_o.mode == MODE_INHERENT
    ) else $error("inherent op decoded an address");

    literal_val_a: assert property (
        req_valid_i && is_lit |=> res_o.literal == $past(op_addr8)
            && res_o.mode == MODE_LITERAL
    ) else $error("literal value wrong");

    branch_target_a: assert property (
        req_valid_i && is_br |=> res_o.target[7:0] == $past(op_addr8)
            && res_o.target[19:8] == $past(req_i.word1[11:0])
    ) else $error("program target wrong");

    banked_addr_a: assert property (
        req_valid_i && is_dir && a_bit && !ind_hit
            |=> res_o.data_addr == {$past(bsr_reg), $past(op_addr8)}
    ) else $error("banked address wrong");

    quick_bank_a: assert property (
        req_valid_i && is_dir && !a_bit && !idx_win && !ind_hit
            |=> res_o.data_addr[7:0] == $past(op_addr8)
            && res_o.data_addr[11:8] == ($past(op_addr8[7])
               ? ACC_HIGH_BANK : ACC_LOW_BANK)
    ) else $error("quick bank address wrong");

    full_addr_a: assert property (
        req_valid_i && is_fdst && !ind_hit
            |=> res_o.data_addr == $past(req_i.word1[11:0])
    ) else $error("full address not used as given");

    full_src_a: assert property (
        req_valid_i && is_fsrc && !ind_hit
            |=> res_o.data_addr == $past(req_i.word0[11:0])
    ) else $error("full source address not used as given");

    target_bit_a: assert property (
        req_valid_i && is_dird |=> res_o.dest_reg == $past(d_bit)
    ) else $error("destination does not follow target bit");

    acc_dest_a: assert property (
        req_valid_i && is_dird && !d_bit |=> !res_o.dest_reg
    ) else $error("result not sent to accumulator");

    fixed_dest_a: assert property (
        req_valid_i && is_dirb |=> res_o.dest_reg == !$past(req_i.fixed_acc)
    ) else $error("fixed destination wrong");

    indirect_addr_a: assert property (
        req_valid_i && ind_hit |=> res_o.mode == MODE_INDIRECT
            && res_o.data_addr == $past(ptr[ind_idx])
    ) else $error("indirect address not taken from pointer");

    post_inc_a: assert property (
        s_step_start |=> ptr[$past(pend_idx_reg)]
            == $past(pend_ptr) + 12'h001
    ) else $error("post increment wrong");

    post_dec_a: assert property (
        s_dec_start |=> ptr[$past(pend_idx_reg)]
            == $past(pend_ptr) - 12'h001
    ) else $error("post decrement wrong");

    hold_ptr_a: assert property (
        s_hold_start |=> $stable(ptr)
    ) else $error("pointer moved before access completed");

    sw_ptr_a: assert property (
        reg_wr_i && ptr_sel[0] |=> ptr[0][7:0] == $past(reg_wdata_i)
    ) else $error("pointer low byte write lost");

    rdata_idle_a: assert property (
        !reg_rd_i |=> reg_rdata_o == RST_BYTE
    ) else $error("read data stood past its cycle");

endmodule : dao_addr_gen

// ### rtl/dao_pkg.sv
// Purpose : Shared types and constants for the data operand addresser.
// Assumes : 12-bit data space, 8-bit data, 20-bit program targets.
// Notes   : Offsets below are data memory addresses of the mapped SFRs.
package dao_pkg;

    // --------------------------------------------------------------
    // Widths
    // --------------------------------------------------------------
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 8;
    localparam int TGT_W   = 20;
    localparam int NUM_PTR = 3;

    typedef logic [ADDR_W-1:0] dao_addr_t;
    typedef logic [DATA_W-1:0] dao_byte_t;

    // --------------------------------------------------------------
    // Opcode field positions
    // --------------------------------------------------------------
    localparam int OP_ADDR_LSB = 0;
    localparam int OP_ADDR_MSB = 7;
    localparam int OP_A_BIT    = 8;
    localparam int OP_D_BIT    = 9;
    localparam int OP_FULL_MSB = 11;

    // --------------------------------------------------------------
    // Address formation constants
    // --------------------------------------------------------------
    localparam logic [3:0] ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
    localparam logic [7:0] IDX_LIMIT     = 8'h5F;
    localparam logic [7:0] IND_PAGE      = 8'hFC;
    localparam logic [1:0] IND_NONE_SLOT = 2'h3;

    // Indirect location kinds, low two address bits
    localparam logic [1:0] IND_PLAIN   = 2'h0;
    localparam logic [1:0] IND_POSTINC = 2'h1;
    localparam logic [1:0] IND_POSTDEC = 2'h2;
    localparam logic [1:0] IND_OFFSET  = 2'h3;

    // --------------------------------------------------------------
    // Mapped SFR addresses
    // --------------------------------------------------------------
    localparam dao_addr_t SFR_PTR_BASE = 12'hFD0;
    localparam dao_addr_t SFR_BSR      = 12'hFE0;
    localparam dao_addr_t SFR_CTRL     = 12'hFE1;
    localparam dao_addr_t SFR_STATUS   = 12'hFE2;
    localparam int        CTRL_EXT_BIT = 0;
    localparam dao_byte_t RST_BYTE     = 8'h00;
    localparam dao_addr_t RST_ADDR     = 12'h000;

    // --------------------------------------------------------------
    // Instruction classes and addressing modes (one-hot)
    // --------------------------------------------------------------
    typedef enum logic [6:0] {
        CLS_INHERENT = 7'b0000001,
        CLS_LITERAL  = 7'b0000010,
        CLS_BRANCH   = 7'b0000100,
        CLS_DIRECT_D = 7'b0001000,
        CLS_DIRECT_B = 7'b0010000,
        CLS_FULL_SRC = 7'b0100000,
        CLS_FULL_DST = 7'b1000000
    } dao_class_e;

    typedef enum logic [4:0] {
        MODE_INHERENT = 5'b00001,
        MODE_LITERAL  = 5'b00010,
        MODE_DIRECT   = 5'b00100,
        MODE_INDIRECT = 5'b01000,
        MODE_INDEXED  = 5'b10000
    } dao_mode_e;

    typedef struct packed {
        dao_class_e  cls;
        logic        fixed_acc;
        logic [15:0] word0;
        logic [15:0] word1;
    } dao_req_s;

    typedef struct packed {
        dao_mode_e        mode;
        logic             has_addr;
        dao_addr_t        data_addr;
        logic             dest_reg;
        dao_byte_t        literal;
        logic [TGT_W-1:0] target;
    } dao_res_s;

endpackage : dao_pkg

// ### rtl/dao_ptr_file.sv
// Purpose : Holds the file select pointers and applies their updates.
// Assumes : Software byte writes and hardware updates share one clock.
// Notes   : A software write wins over a same-cycle hardware update.
`timescale 1ns/100ps
module dao_ptr_file
    import dao_pkg::*;
(
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    input  wire logic [2*NUM_PTR-1:0]       sw_wr_i,
    input  wire dao_byte_t                  sw_data_i,
    input  wire logic                       upd_i,
    input  wire logic [1:0]                 upd_idx_i,
    input  wire logic [1:0]                 upd_kind_i,
    input  wire dao_byte_t                  upd_off_i,
    output logic [NUM_PTR-1:0][ADDR_W-1:0]  ptr_o
);

    // --------------------------------------------------------------
    // Offset is signed, so the pointer can walk both ways
    // --------------------------------------------------------------
    wire dao_addr_t off_ext = {{(ADDR_W-DATA_W){upd_off_i[DATA_W-1]}},
                               upd_off_i};

    genvar p;
    generate
        for (p = 0; p < NUM_PTR; p++) begin : g_ptr
            dao_addr_t ptr_reg;
            dao_addr_t ptr_next;
            wire       hit = upd_i && (upd_idx_i == 2'(p));

            always_comb begin
                unique case (upd_kind_i)
                    IND_POSTINC: ptr_next = ptr_reg + 12'h001;
                    IND_POSTDEC: ptr_next = ptr_reg - 12'h001;
                    IND_OFFSET:  ptr_next = ptr_reg + off_ext;
                    IND_PLAIN:   ptr_next = ptr_reg;
                endcase
            end

            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    ptr_reg <= RST_ADDR;
                end else if (sw_wr_i[2*p]) begin
                    ptr_reg[7:0] <= sw_data_i;
                end else if (sw_wr_i[2*p+1]) begin
                    ptr_reg[ADDR_W-1:8] <= sw_data_i[3:0];
                end else if (hit) begin
                    ptr_reg <= ptr_next;
                end
            end

            assign ptr_o[p] = ptr_reg;
        end
    endgenerate

endmodule : dao_ptr_file

// ### tb/dao_addr_gen_tb.sv
// Purpose : Self-checking bench for the operand addresser.
// Assumes : Register port and request port per hand-over contract.
// Notes   : Pointer updates are judged by reading the pointers back.
`timescale 1ns/100ps
module dao_addr_gen_tb;
    import dao_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       req_valid_i = 1'b0;
    dao_req_s   req_i = '0;
    dao_byte_t  acc_i = 8'h00;
    logic       access_done_i;
    dao_addr_t  reg_addr_i = 12'h000;
    dao_byte_t  reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    dao_byte_t  reg_rdata_o;
    logic       res_valid_o;
    dao_res_s   res_o;
    logic [3:0] delay = 4'h0;
    int         error_cnt = 0;
    int         n_compared = 0;

    always #5 core_clk_i = ~core_clk_i;

    dao_addr_gen u_dao_addr_gen (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .acc_i(acc_i),
        .access_done_i(access_done_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .res_valid_o(res_valid_o), .res_o(res_o));

    dao_exec_model u_dao_exec_model (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .res_valid_i(res_valid_o), .res_i(res_o), .delay_i(delay),
        .access_done_o(access_done_i));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input dao_addr_t a, input dao_byte_t d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input dao_addr_t a, output dao_byte_t d);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        d = reg_rdata_o;
        @(posedge core_clk_i);
        #1;
        check("rdata stands", reg_rdata_o, 8'h00);
    endtask : reg_read

    // Sends one request and returns the registered result
    task automatic send(input dao_class_e c, input logic fa,
                        input logic [15:0] w0, input logic [15:0] w1,
                        output dao_res_s r);
        @(posedge core_clk_i);
        req_valid_i <= 1'b1;
        req_i       <= '{cls: c, fixed_acc: fa, word0: w0, word1: w1};
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        #1;
        check("res_valid", res_valid_o, 1'b1);
        r = res_o;
        @(posedge core_clk_i);
        #1;
        check("res_valid drop", res_valid_o, 1'b0);
    endtask : send

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic test_regs;
        dao_byte_t d;
        reg_read(SFR_BSR, d);
        check("bank reset", d, 8'h00);
        reg_write(SFR_BSR, 8'h12);
        reg_read(SFR_BSR, d);
        check("bank nibble", d, 8'h02);
        reg_write(12'hFD1, 8'hF1);
        reg_read(12'hFD1, d);
        check("ptr0 high", d, 8'h01);
        reg_read(12'h100, d);
        check("unmapped", d, 8'h00);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_direct;
        dao_res_s r;
        send(CLS_DIRECT_D, 1'b0, 16'h0334, 16'h0000, r);
        check("bank addr", r.data_addr, 12'h234);
        check("mode dir", r.mode, MODE_DIRECT);
        check("dest reg", r.dest_reg, 1'b1);
        send(CLS_DIRECT_D, 1'b0, 16'h0090, 16'h0000, r);
        check("quick high", r.data_addr, 12'hF90);
        check("dest acc", r.dest_reg, 1'b0);
        send(CLS_DIRECT_B, 1'b0, 16'h007F, 16'h0000, r);
        check("quick low", r.data_addr, 12'h07F);
        send(CLS_FULL_SRC, 1'b0, 16'h0ABC, 16'h0000, r);
        check("full src", r.data_addr, 12'hABC);
        send(CLS_FULL_DST, 1'b0, 16'h0000, 16'h0DEF, r);
        check("full dst", r.data_addr, 12'hDEF);
        $display("test_direct done");
    endtask : test_direct

    task automatic test_nonaddr;
        dao_res_s r;
        send(CLS_LITERAL, 1'b0, 16'h0EA5, 16'h0000, r);
        check("literal", r.literal, 8'hA5);
        check("lit mode", r.mode, MODE_LITERAL);
        send(CLS_BRANCH, 1'b0, 16'h0E5A, 16'hF9C3, r);
        check("target", r.target, 20'h9C35A);
        send(CLS_INHERENT, 1'b1, 16'h0007, 16'h0000, r);
        check("inh addr", r.has_addr, 1'b0);
        check("inh acc", r.dest_reg, 1'b0);
        send(CLS_INHERENT, 1'b0, 16'h0007, 16'h0000, r);
        check("inh reg", r.dest_reg, 1'b1);
        $display("test_nonaddr done");
    endtask : test_nonaddr

    // Walks every indirect location kind on pointer 0
    task automatic test_indirect;
        dao_res_s  r;
        dao_byte_t lo;
        dao_byte_t hi;
        dao_addr_t p;
        p = 12'h123;
        reg_write(12'hFD0, 8'h23);
        reg_write(12'hFD1, 8'h01);
        acc_i <= 8'hFE;
        for (int k = 0; k < 4; k++) begin
            delay = (k == 1) ? 4'h0 : 4'h6;
            send(CLS_DIRECT_D, 1'b0, 16'h00C0 + k[15:0], 16'h0000, r);
            check("ind addr", r.data_addr, p);
            check("ind mode", r.mode, MODE_INDIRECT);
            for (int i = 0; i < 20 && access_done_i !== 1'b1; i++)
                @(posedge core_clk_i);
            if (k == 1) p = p + 12'h001;
            if (k == 2) p = p - 12'h001;
            if (k == 3) p = p - 12'h002;
            reg_read(12'hFD0, lo);
            reg_read(12'hFD1, hi);
            check("ptr after", {hi[3:0], lo}, p);
        end
        reg_read(SFR_STATUS, lo);
        check("status", lo, {3'h0, MODE_INDIRECT});
        $display("test_indirect done");
    endtask : test_indirect

    task automatic test_indexed;
        dao_res_s  r;
        dao_byte_t d;
        reg_write(SFR_CTRL, 8'h01);
        reg_read(SFR_CTRL, d);
        check("ext enable", d, 8'h01);
        reg_write(12'hFD4, 8'h40);
        reg_write(12'hFD5, 8'h02);
        send(CLS_DIRECT_D, 1'b0, 16'h005F, 16'h0000, r);
        check("idx addr", r.data_addr, 12'h29F);
        check("idx mode", r.mode, MODE_INDEXED);
        send(CLS_DIRECT_D, 1'b0, 16'h0060, 16'h0000, r);
        check("idx edge", r.data_addr, 12'h060);
        reg_write(SFR_CTRL, 8'h00);
        send(CLS_DIRECT_D, 1'b0, 16'h0010, 16'h0000, r);
        check("ext off", r.mode, MODE_DIRECT);
        $display("test_indexed done");
    endtask : test_indexed

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        test_regs();
        test_direct();
        test_nonaddr();
        test_indirect();
        test_indexed();
        print_verdict();
    end

    initial begin
        #100us;
        error_cnt++;
        print_verdict();
    end
endmodule : dao_addr_gen_tb

// ### tb/dao_exec_model.sv
// Purpose : Execution unit stand-in that finishes operand accesses.
// Assumes : Only indirect results start an access that needs a done pulse.
// Notes   : Delay input lets the bench answer promptly or slowly.
`timescale 1ns/100ps
module dao_exec_model
    import dao_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       res_valid_i,
    input  wire dao_res_s   res_i,
    input  wire logic [3:0] delay_i,
    output logic            access_done_o
);
    logic [3:0] wait_cnt;
    logic       busy;

    // --------------------------------------------------------------
    // Access completion
    // --------------------------------------------------------------
    // done after access
    always_ff @(posedge core_clk_i) begin
        access_done_o <= 1'b0;
        if (rst_i) begin
            busy     <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (res_valid_i && res_i.mode == MODE_INDIRECT) begin
            busy     <= 1'b1;
            wait_cnt <= delay_i;
        end else if (busy) begin
            if (wait_cnt == 4'h0) begin
                access_done_o <= 1'b1;
                busy          <= 1'b0;
            end else begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule : dao_exec_model
